// ==== bench/drsu_mem_model.sv ====
/*
 * drsu_mem_model: memory side of the maintenance unit. Answers every
 * write cycle and the no-op data phase with a one-cycle done pulse after
 * a chosen number of wait cycles, and logs what it was handed.
 * Assumes the unit holds address, data and the no-op word until done.
 */
module drsu_mem_model
   import drsu_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic [3:0] lat, // wait cycles before each answer
   input wire logic mem_start_q, // write cycle start
   input wire logic [WORD_W-1:0] mem_addr_q, // write address
   input wire logic [WORD_W-1:0] mem_wdata_q, // write data
   input wire logic [WORD_W-1:0] lines_q, // data lines from the unit
   input wire logic lines_oe_q, // data lines driven
   output logic mem_done // cycle complete, one-cycle pulse
);
   timeunit 1ns;
   timeprecision 1ps;

   logic busy_q = 1'b0;
   logic nop_q = 1'b0;
   logic nop_done_q = 1'b0;
   logic [3:0] cnt_q = 4'h0;
   logic [WORD_W-1:0] wr_addr[$];
   logic [WORD_W-1:0] wr_data[$];
   logic [WORD_W-1:0] nop_seen = 18'h0_0000;

   always @(posedge clk) begin
      mem_done <= 1'b0;
      if (!reset_n) begin
         busy_q <= 1'b0;
      end else if (busy_q) begin
         if (cnt_q == 4'h0) begin
            mem_done <= 1'b1;
            busy_q <= 1'b0;
            if (nop_q) begin
               nop_seen <= lines_q;
            end else begin
               wr_addr.push_back(mem_addr_q);
               wr_data.push_back(mem_wdata_q);
            end
         end else begin
            cnt_q <= cnt_q - 4'h1;
         end
      end else if (mem_start_q || (lines_oe_q && !nop_done_q)) begin
         busy_q <= 1'b1;
         nop_q <= !mem_start_q;
         cnt_q <= lat;
      end
   end

   // the no-op phase is answered once, even while the lines stay driven
   always @(posedge clk) begin
      if (!reset_n || !lines_oe_q) begin
         nop_done_q <= 1'b0;
      end else if (busy_q && nop_q && cnt_q == 4'h0) begin
         nop_done_q <= 1'b1;
      end
   end
endmodule : drsu_mem_model

// ==== bench/tb_top.sv ====
/*
 * tb_top: self-checking bench of the maintenance unit: reads, refused
 * intake, and step-and-read runs ending on step count, end of cycle and
 * interrupt. Assumes the memory model answers every cycle it is offered.
 */
module tb_top
   import drsu_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic diag_mode_on = 1'b0;
   logic fp_busy = 1'b0;
   logic instr_valid = 1'b0;
   logic end_nor_write = 1'b0;
   logic [17:0] instr_word = 18'h0_0000;
   logic [17:0] addr_word = 18'h0_0000;
   logic [3:0] lat = 4'h0;
   logic mem_done;
   drsu_snap_s snap;
   drsu_cyc_s cyc;
   drsu_step_s step_ev;
   logic mem_start_q, lines_oe_q, run_q, done_q, clear_q, entry_q;
   logic [17:0] mem_addr_q, mem_wdata_q, lines_q, dir_q;
   logic [4:0] cnt_q;
   int bad_count = 0;
   int check_count = 0;
   int wr_base = 0;

   always #5 clk = ~clk;

   diag_read_step_unit diag_read_step_unit_i (.clk(clk), .reset_n(reset_n),
      .diag_mode_on(diag_mode_on), .fp_busy(fp_busy),
      .instr_valid(instr_valid), .instr_word(instr_word),
      .addr_word(addr_word), .mem_done(mem_done), .snap(snap), .cyc(cyc),
      .step_ev(step_ev), .end_nor_write(end_nor_write),
      .mem_start_q(mem_start_q), .mem_addr_q(mem_addr_q),
      .mem_wdata_q(mem_wdata_q), .memory_data_lines_q(lines_q),
      .memory_data_lines_oe_q(lines_oe_q), .fp_clk_run_q(run_q),
      .transfer_done_flag_q(done_q), .fp_clear_q(clear_q),
      .entry_diag_q(entry_q), .word_transfer_counter_q(cnt_q),
      .diag_instr_q(dir_q));

   drsu_mem_model mem_i (.clk(clk), .reset_n(reset_n), .lat(lat),
      .mem_start_q(mem_start_q), .mem_addr_q(mem_addr_q),
      .mem_wdata_q(mem_wdata_q), .lines_q(lines_q), .lines_oe_q(lines_oe_q),
      .mem_done(mem_done));

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test

   task automatic check(input string what, input logic [17:0] seen,
      input logic [17:0] want);
      check_count++;
      if (seen !== want) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, want, seen);
      end
   endtask : check

   task automatic bound(input int i, input int lim);
      if (i >= lim) begin
         bad_count++;
         $display("unexpected wait: expected below %0d, seen %0d", lim, i);
         finish_test();
      end
   endtask : bound

   function automatic logic [17:0] want_word(input int k, input logic busy,
      input logic [5:0] field);
      case (k)
         0: return snap.buffered_mem_word[35:18];
         1: return snap.buffered_mem_word[17:0];
         2: return {snap.shift_count, snap.instr_reg};
         3: return snap.exponent_a;
         4: return {snap.a_sign, snap.mantissa_a[34:18]};
         5: return snap.mantissa_a[17:0];
         6: return snap.exponent_b;
         7: return {snap.b_sign, snap.mantissa_b[34:18]};
         8: return snap.mantissa_b[17:0];
         9: return {snap.b_sign, snap.mantissa_quotient[34:18]};
         10: return snap.mantissa_quotient[17:0];
         11: return snap.alu_sum[35:18];
         12: return snap.alu_sum[17:0];
         13: return snap.subroutine_exit_addr;
         14: return {busy, cyc, field};
         default: return snap.operand_addr_reg;
      endcase
   endfunction : want_word

   task automatic issue(input logic [17:0] iw, input logic [17:0] aw);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word <= iw;
      addr_word <= aw;
      wr_base = mem_i.wr_addr.size();
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
   endtask : issue

   task automatic finish_dump(input logic [17:0] arg, input logic [5:0] fld,
      input logic busy, input logic run_want);
      int i;
      int td;
      td = 0;
      for (i = 0; i < 800 && clear_q !== 1'b1; i++) begin
         @(posedge clk);
         #1;
         if (done_q === 1'b1) td++;
      end
      bound(i, 800);
      check("no-op word", mem_i.nop_seen, NOP_WORD);
      check("words", 18'(mem_i.wr_addr.size() - wr_base), 18'h0_0010);
      for (int k = 0; k < 16; k++) begin
         check("address", mem_i.wr_addr[wr_base + k], 18'(arg + k));
         check("word", mem_i.wr_data[wr_base + k],
            want_word(k, busy, fld));
      end
      check("counter", {13'h0000, cnt_q}, 18'h0_0010);
      check("done pulses", 18'(td), 18'h0_0001);
      check("clock run", {17'h0_0000, run_q}, {17'h0_0000, run_want});
      check("entry", {17'h0_0000, entry_q}, {17'h0_0000, busy});
   endtask : finish_dump

   task automatic start_step(input logic [5:0] n);
      int i;
      issue(18'(STEP_READ_BASE + n), 18'h0_1000);
      check("clock halted", {17'h0_0000, run_q}, 18'h0_0000);
      for (i = 0; i < 100 && run_q !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      bound(i, 100);
   endtask : start_step

   task automatic step_pulse(input int b, input logic [17:0] dir_want);
      @(posedge clk);
      step_ev <= drsu_step_s'(8'h01 << b);
      @(posedge clk);
      step_ev <= '0;
      #1;
      check("step field", dir_q, dir_want);
   endtask : step_pulse

   initial begin
      for (int b = 0; b < $bits(snap); b++) snap[b] = ((b * 37) % 11) > 4;
      cyc = '0;
      cyc.fetch_cycle = 1'b1;
      cyc.time_state_three = 1'b1;
      step_ev = '0;
      repeat (12) @(posedge clk);
      #1;
      check("reset oe", {17'h0_0000, lines_oe_q}, 18'h0_0000);
      check("reset run", {17'h0_0000, run_q}, 18'h0_0001);
      check("reset counter", {13'h0000, cnt_q}, 18'h0_0000);
      @(posedge clk);
      reset_n <= 1'b1;
      diag_mode_on <= 1'b1;
      fp_busy <= 1'b1;
      issue(18'h3_9015, 18'h0_0400);
      finish_dump(18'h0_0400, 6'h15, 1'b1, 1'b0);
      @(posedge clk);
      lat <= 4'h3;
      issue(18'h3_902A, 18'h3_FFF0);
      finish_dump(18'h3_FFF0, 6'h2A, 1'b1, 1'b0);
      @(posedge clk);
      diag_mode_on <= 1'b0;
      issue(18'h3_9041, 18'h0_0200);
      repeat (10) @(posedge clk);
      #1;
      check("refused oe", {17'h0_0000, lines_oe_q}, 18'h0_0000);
      check("refused count", {13'h0000, cnt_q}, 18'h0_0010);
      @(posedge clk);
      diag_mode_on <= 1'b1;
      start_step(6'h08);
      for (int b = 0; b < 8; b++) begin
         step_pulse(b, 18'(STEP_READ_BASE + 7 - b));
         if (b < 7) check("stepping", {17'h0_0000, run_q}, 18'h0_0001);
      end
      finish_dump(18'h0_1000, 6'h00, 1'b1, 1'b0);
      @(posedge clk);
      lat <= 4'h0;
      start_step(6'h05);
      step_pulse(2, 18'(STEP_READ_BASE + 4));
      @(posedge clk);
      fp_busy <= 1'b0;
      end_nor_write <= 1'b1;
      finish_dump(18'h0_1000, 6'h04, 1'b0, 1'b1);
      @(posedge clk);
      fp_busy <= 1'b1;
      end_nor_write <= 1'b0;
      start_step(6'h05);
      @(posedge clk);
      cyc.int_phase_one <= 1'b1;
      finish_dump(18'h0_1000, 6'h05, 1'b1, 1'b0);
      finish_test();
   end
endmodule : tb_top

// ==== core/diag_read_step_unit.sv ====
/*
 * diag_read_step_unit: maintenance sequencer of the floating-point
 * coprocessor. Takes a maintenance instruction and its address word,
 * completes the pending cpu fetch with a no-op word, then either dumps
 * sixteen internal words to memory or steps the suspended instruction
 * and dumps afterwards.
 * Assumes the memory side answers each started cycle with mem_done and
 * that the datapath holds its registers while fp_clk_run_q is low.
 */
// Contract
// - instruction bit 11 clear: diagnostic read, instruction stays suspended.
// - read moves sixteen 18-bit words singly, first to the argument address.
// - words 1-11: buffer word, shift/instr, exponents, mantissas, quotient.
// - words 12-16: alu sum hi, lo, exit address, status word, operand address.
// - every dumped word starts its own memory cycle.
// - word transfer counter increments once per word moved.
// - status: busy, cycle flags, interrupt phases, time states, step field.
// - address register steps per word: sixteen consecutive locations.
// - counter carry at sixteen sets done flag, clears unit, returns to cpu.
// - reading may repeat without disturbing the suspended instruction.
// - instruction bit 11 set means step and read.
// - datapath picks cycles while stepping; indirection, skips are its own.
// - stepping restarts the processor clock halted at time state three.
// - each listed phase-two condition or shift pulse counts one step; code counts pulses in one cycle as one step.
// - the step field decrements once per counted step.
// - steps left and not at end point or interrupt: keep stepping.
// - at end point or interrupt with busy set: stop clock, then dump.
// - at those points with instruction complete: clock keeps running, dump.
// - after sixteenth word the carry ends the cycle and returns to cpu.
// - next instruction re-enters diagnostic path if still busy, else normal.
// - busy in maintenance mode: load instruction and following address word.
// - complete the cpu fetch by driving the no-op word on memory data.
module diag_read_step_unit
   import drsu_pkg::*;
#(
   parameter int WORDS = DUMP_WORDS
)(
   input wire logic clk, // core clock, 100 MHz
   input wire logic reset_n, // synchronous reset, active low
   input wire logic diag_mode_on, // maintenance mode enabled
   input wire logic fp_busy, // floating-point instruction busy
   input wire logic instr_valid, // instruction and address word present
   input wire logic [WORD_W-1:0] instr_word, // maintenance instruction
   input wire logic [WORD_W-1:0] addr_word, // argument address word
   input wire logic mem_done, // memory cycle complete
   input wire drsu_snap_s snap, // internal register snapshot
   input wire drsu_cyc_s cyc, // major cycle and time state
   input wire drsu_step_s step_ev, // step events, one-cycle pulses
   input wire logic end_nor_write, // at end of normalize or write cycle
   output logic mem_start_q, // start of a memory write cycle
   output logic [WORD_W-1:0] mem_addr_q, // memory write address
   output logic [WORD_W-1:0] mem_wdata_q, // memory write data
   output logic [WORD_W-1:0] memory_data_lines_q, // data lines out
   output logic memory_data_lines_oe_q, // data lines driven
   output logic fp_clk_run_q, // processor clock enabled
   output logic transfer_done_flag_q, // all words transferred
   output logic fp_clear_q, // clear pulse, control back to cpu
   output logic entry_diag_q, // next entry by diagnostic path
   output logic [XFER_CNT_W-1:0] word_transfer_counter_q, // words moved
   output logic [WORD_W-1:0] diag_instr_q // diagnostic instruction reg
);

   typedef enum logic [2:0] {
      S_IDLE, S_NOP, S_STEP, S_PREP, S_WAIT, S_DONE
   } drsu_state_e;

   drsu_state_e state_q, state_d;
   logic [WORD_W-1:0] diag_addr_reg_q;
   logic [WORD_W-1:0] status_word;
   logic [SEL_W-1:0] word_sel;
   logic accept;
   logic mode_step;
   logic step_hit;
   logic at_stop_point;
   logic [STEP_W-1:0] step_field;
   logic [STEP_W-1:0] step_field_dec;
   logic steps_exhausted;
   logic leave_step;
   logic word_done;
   logic [XFER_CNT_W-1:0] cnt_inc;
   logic dump_count_carry;

   if (WORDS != DUMP_WORDS) begin : g_words_chk
      $error("diag_read_step_unit: WORDS must equal the dump length");
   end

   // while busy in maintenance mode any fp instruction is maintenance
   assign accept = instr_valid && diag_mode_on && fp_busy;
   assign mode_step = diag_instr_q[DIR_MODE_BIT];

   assign step_hit = |step_ev;
   // interrupt sequence or the end of normalize/write ends stepping
   assign at_stop_point = end_nor_write || cyc.int_phase_one ||
                          cyc.int_phase_two;
   assign step_field = diag_instr_q[STEP_W-1:0];
   assign step_field_dec = step_field - STEP_ONE;
   assign steps_exhausted = step_hit && (step_field_dec == STEP_ZERO);
   assign leave_step = at_stop_point || steps_exhausted;

   assign word_done = (state_q == S_WAIT) && mem_done;
   assign cnt_inc = word_transfer_counter_q + CNT_ONE;
   assign dump_count_carry = word_done && cnt_inc[XFER_CNT_W-1];
   assign word_sel = word_transfer_counter_q[SEL_W-1:0];

   // status layout, bit 00 (msb) first
   assign status_word = {fp_busy,
                         cyc.fetch_cycle, cyc.operand_cycle,
                         cyc.exponent_cycle, cyc.function_cycle,
                         cyc.normalize_cycle, cyc.write_cycle,
                         cyc.int_phase_one, cyc.int_phase_two,
                         cyc.time_state_one, cyc.time_state_two,
                         cyc.time_state_three,
                         diag_instr_q[STEP_W-1:0]};

   // the selector only reads the snapshot, so a read leaves the
   // suspended instruction untouched and may be repeated
   drsu_word_sel u_word_sel (
      .clk(clk),
      .reset_n(reset_n),
      .sel(word_sel),
      .snap(snap),
      .status_word(status_word),
      .word_q(mem_wdata_q)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (accept) begin
               state_d = S_NOP;
            end
         end
         S_NOP: begin
            if (mem_done) begin
               state_d = mode_step ? S_STEP : S_PREP;
            end
         end
         // cycle choice stays with the datapath; only steps are counted
         S_STEP: begin
            if (leave_step) begin
               state_d = S_PREP;
            end
         end
         S_PREP: state_d = S_WAIT;
         S_WAIT: begin
            if (dump_count_carry) begin
               state_d = S_DONE;
            end else if (word_done) begin
               state_d = S_PREP;
            end
         end
         S_DONE: state_d = S_IDLE;
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q <= S_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // instruction and address capture, step countdown, address walk
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         diag_instr_q <= DIR_RESET;
         diag_addr_reg_q <= ADDR_RESET;
      end else if (state_q == S_IDLE && accept) begin
         diag_instr_q <= instr_word;
         diag_addr_reg_q <= addr_word;
      end else begin
         if (state_q == S_STEP && step_hit) begin
            diag_instr_q[STEP_W-1:0] <= step_field_dec;
         end
         if (word_done) begin
            diag_addr_reg_q <= diag_addr_reg_q + ADDR_ONE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         word_transfer_counter_q <= CNT_ZERO;
      end else if (state_q == S_IDLE && accept) begin
         word_transfer_counter_q <= CNT_ZERO;
      end else if (word_done) begin
         word_transfer_counter_q <= cnt_inc;
      end
   end

   // one memory cycle per word, raised as the selected word lands
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mem_start_q <= 1'b0;
         mem_addr_q <= ADDR_RESET;
      end else begin
         mem_start_q <= (state_q == S_PREP);
         mem_addr_q <= diag_addr_reg_q;
      end
   end

   // no-op word completes the cpu's pending instruction fetch
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         memory_data_lines_q <= DIR_RESET;
         memory_data_lines_oe_q <= 1'b0;
      end else if (state_q == S_IDLE && accept) begin
         memory_data_lines_q <= NOP_WORD;
         memory_data_lines_oe_q <= 1'b1;
      end else if (state_q == S_NOP && mem_done) begin
         memory_data_lines_q <= DIR_RESET;
         memory_data_lines_oe_q <= 1'b0;
      end
   end

   // clock run control: held halted while suspended, released to step
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fp_clk_run_q <= 1'b1;
      end else if (state_q == S_IDLE && accept) begin
         fp_clk_run_q <= 1'b0;
      end else if (state_q == S_NOP && mem_done && mode_step) begin
         fp_clk_run_q <= 1'b1;
      end else if (state_q == S_STEP && leave_step) begin
         fp_clk_run_q <= !fp_busy;
      end
   end

   // done flag lives one cycle; the clear pulse follows it
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         transfer_done_flag_q <= 1'b0;
         fp_clear_q <= 1'b0;
         entry_diag_q <= 1'b0;
      end else begin
         transfer_done_flag_q <= dump_count_carry;
         fp_clear_q <= (state_q == S_DONE);
         if (state_q == S_DONE) begin
            entry_diag_q <= fp_busy;
         end
      end
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   mem_cycle_pulse_a: assert property (
      mem_start_q |=> !mem_start_q ##1 !mem_start_q)
      else $error("memory start not a single pulse");

   counter_per_word_a: assert property (
      (word_done && !dump_count_carry) |=>
         word_transfer_counter_q == $past(word_transfer_counter_q) + 5'h01)
      else $error("transfer counter did not step on a word");

   addr_walk_a: assert property (
      word_done |=> diag_addr_reg_q == $past(diag_addr_reg_q) + 18'h0_0001)
      else $error("address register did not step on a word");

   nop_drive_a: assert property (
      state_q == S_NOP |->
         memory_data_lines_oe_q && memory_data_lines_q == NOP_WORD)
      else $error("no-op word not on the data lines");

   done_clears_a: assert property (
      transfer_done_flag_q |=> fp_clear_q ##1 !fp_clear_q)
      else $error("done flag did not lead to one clear pulse");

   first_addr_a: assert property (
      (state_q == S_NOP && mem_done && !mode_step) |=>
         ##1 mem_start_q && mem_addr_q == $past(diag_addr_reg_q, 2))
      else $error("first word not sent to the argument address");

   step_dec_a: assert property (
      (state_q == S_STEP && step_hit) |=>
         diag_instr_q[STEP_W-1:0] ==
         $past(diag_instr_q[STEP_W-1:0]) - 6'h01)
      else $error("step field did not decrement");

   clock_restart_a: assert property (
      (state_q == S_NOP && mem_done && mode_step) |=>
         fp_clk_run_q && state_q == S_STEP)
      else $error("clock not restarted for stepping");

   stop_busy_a: assert property (
      (state_q == S_STEP && leave_step && fp_busy) |=>
         !fp_clk_run_q && state_q == S_PREP)
      else $error("clock not stopped at busy stop point");

   read_no_run_a: assert property (
      (state_q == S_NOP && mem_done && !mode_step) |=>
         !fp_clk_run_q throughout (state_q != S_DONE) [*3])
      else $error("read let the suspended instruction run");

   keep_step_a: assert property (
      (state_q == S_STEP && !leave_step) |=> state_q == S_STEP)
      else $error("stepping ended with steps left");

   done_at_carry_a: assert property (
      dump_count_carry |=> transfer_done_flag_q &&
         word_transfer_counter_q == XFER_CNT_W'(DUMP_WORDS))
      else $error("carry did not set the done flag at sixteen");

   carry_ends_a: assert property (
      dump_count_carry |=> state_q == S_DONE ##1
         fp_clear_q && state_q == S_IDLE)
      else $error("carry did not end the dump and return");

   run_keep_a: assert property (
      (state_q == S_STEP && leave_step && !fp_busy) |=>
         fp_clk_run_q && state_q == S_PREP)
      else $error("clock stopped although instruction complete");

   entry_path_a: assert property (
      state_q == S_DONE |=> entry_diag_q == $past(fp_busy))
      else $error("entry path does not follow busy");

   step_exhaust_a: assert property (
      (state_q == S_STEP && step_hit && step_field == STEP_ONE) |=>
         state_q == S_PREP)
      else $error("last step did not start the dump");

   intake_load_a: assert property (
      (state_q == S_IDLE && accept) |=> state_q == S_NOP &&
         diag_instr_q == $past(instr_word) &&
         diag_addr_reg_q == $past(addr_word) && !fp_clk_run_q)
      else $error("maintenance instruction not taken in");

   refuse_idle_a: assert property (
      (state_q == S_IDLE && !(diag_mode_on && fp_busy)) |=>
         state_q == S_IDLE)
      else $error("instruction taken outside busy maintenance mode");

   status_layout_a: assert property (
      (state_q == S_PREP && drsu_word_e'(word_sel) == W_STATUS) |=>
         mem_wdata_q == {$past(fp_busy), $past(cyc),
                         $past(diag_instr_q[STEP_W-1:0])})
      else $error("status word layout wrong");

endmodule : diag_read_step_unit

// ==== core/drsu_pkg.sv ====
/*
 * drsu_pkg: constants, word layouts and carrier types for the diagnostic
 * read / step-and-read unit of the floating-point coprocessor.
 * Assumes 18-bit memory words with the most significant bit numbered 00.
 */
package drsu_pkg;

   localparam int WORD_W = 18;
   localparam int DUMP_WORDS = 16;
   localparam int XFER_CNT_W = 5;
   localparam int STEP_W = 6;
   localparam int SEL_W = 4;

   // instruction bit 11 (msb = bit 00) selects step-and-read
   localparam int DIR_MODE_BIT = 6;

   // no-operation word forced onto the memory data lines
   localparam logic [17:0] NOP_WORD = 18'h3_9000;
   // base of a step-and-read instruction, step count added by software
   localparam logic [17:0] STEP_READ_BASE = 18'h3_9040;

   localparam logic [17:0] DIR_RESET = 18'h0_0000;
   localparam logic [17:0] ADDR_RESET = 18'h0_0000;
   localparam logic [XFER_CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [XFER_CNT_W-1:0] CNT_ONE = 5'h01;
   localparam logic [17:0] ADDR_ONE = 18'h0_0001;
   localparam logic [STEP_W-1:0] STEP_ONE = 6'h01;
   localparam logic [STEP_W-1:0] STEP_ZERO = 6'h00;

   typedef enum logic [SEL_W-1:0] {
      W_BUF_HI, W_BUF_LO, W_SHIFT_INSTR, W_EXPO_A, W_MA_HI, W_MA_LO,
      W_EXPO_B, W_MB_HI, W_MB_LO, W_MQ_HI, W_MQ_LO, W_SUM_HI,
      W_SUM_LO, W_EXIT, W_STATUS, W_OPADDR
   } drsu_word_e;

   // internal register snapshot presented by the datapath
   typedef struct packed {
      logic [35:0] buffered_mem_word;
      logic [5:0] shift_count;
      logic [11:0] instr_reg;
      logic [17:0] exponent_a;
      logic a_sign;
      logic [34:0] mantissa_a;
      logic [17:0] exponent_b;
      logic b_sign;
      logic [34:0] mantissa_b;
      logic [34:0] mantissa_quotient;
      logic [35:0] alu_sum;
      logic [17:0] subroutine_exit_addr;
      logic [17:0] operand_addr_reg;
   } drsu_snap_s;

   // major cycle and timing state of the processor
   typedef struct packed {
      logic fetch_cycle;
      logic operand_cycle;
      logic exponent_cycle;
      logic function_cycle;
      logic normalize_cycle;
      logic write_cycle;
      logic int_phase_one;
      logic int_phase_two;
      logic time_state_one;
      logic time_state_two;
      logic time_state_three;
   } drsu_cyc_s;

   // one-cycle events; any number of them in one cycle counts as a single step
   typedef struct packed {
      logic ph2_ts3_cond;
      logic ph2_clk_cond;
      logic align_step_pulse;
      logic b_right_shift_pulse;
      logic muldiv_shift_pulse;
      logic int_divide_pulse;
      logic fix_shift_pulse;
      logic normalize_shift_pulse;
   } drsu_step_s;

endpackage : drsu_pkg

// ==== core/drsu_word_sel.sv ====
/*
 * drsu_word_sel: selects one of the sixteen dump words and holds it in
 * a register for the memory write.
 * Assumes the selector and sources are stable for one cycle before use.
 */
module drsu_word_sel
   import drsu_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic [SEL_W-1:0] sel, // dump word index
   input wire drsu_snap_s snap, // register snapshot
   input wire logic [WORD_W-1:0] status_word, // processor status word
   output logic [WORD_W-1:0] word_q // registered dump word
);

   logic [WORD_W-1:0] word_d;

   always_comb begin
      case (drsu_word_e'(sel))
         W_BUF_HI: word_d = snap.buffered_mem_word[35:18];
         W_BUF_LO: word_d = snap.buffered_mem_word[17:0];
         W_SHIFT_INSTR: word_d = {snap.shift_count, snap.instr_reg};
         W_EXPO_A: word_d = snap.exponent_a;
         W_MA_HI: word_d = {snap.a_sign, snap.mantissa_a[34:18]};
         W_MA_LO: word_d = snap.mantissa_a[17:0];
         W_EXPO_B: word_d = snap.exponent_b;
         W_MB_HI: word_d = {snap.b_sign, snap.mantissa_b[34:18]};
         W_MB_LO: word_d = snap.mantissa_b[17:0];
         W_MQ_HI: word_d = {snap.b_sign,
                            snap.mantissa_quotient[34:18]};
         W_MQ_LO: word_d = snap.mantissa_quotient[17:0];
         W_SUM_HI: word_d = snap.alu_sum[35:18];
         W_SUM_LO: word_d = snap.alu_sum[17:0];
         W_EXIT: word_d = snap.subroutine_exit_addr;
         W_STATUS: word_d = status_word;
         W_OPADDR: word_d = snap.operand_addr_reg;
         default: word_d = snap.operand_addr_reg;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         word_q <= DIR_RESET;
      end else begin
         word_q <= word_d;
      end
   end

endmodule : drsu_word_sel
